// ==== include/paem_regs.vh ====
// register map, field positions, reset values and timing for the mode register bank
`ifndef PAEM_REGS_VH
`define PAEM_REGS_VH

// ---------------------------------------------------------------
// register indexes on the management interface
// ---------------------------------------------------------------
`define PAEM_IDX_AUTONEG_EXPANSION_STATUS    5'h06
`define PAEM_IDX_SLEEP_XOVER_CFG 5'h10
`define PAEM_IDX_ENERGY_MODE     5'h11
`define PAEM_IDX_OPMODE_ADDR     5'h12

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PAEM_EXP_PD_FAULT        4
`define PAEM_EXP_LP_NP_ABLE      3
`define PAEM_EXP_NP_ABLE         2
`define PAEM_EXP_PAGE_RX         1
`define PAEM_EXP_LP_AN_ABLE      0
`define PAEM_CFG_TX_NLP_EN       15
`define PAEM_CFG_TX_IVAL_HI      14
`define PAEM_CFG_TX_IVAL_LO      13
`define PAEM_CFG_RX_SINGLE_WAKE  12
`define PAEM_CFG_RX_IVAL_HI      11
`define PAEM_CFG_RX_IVAL_LO      10
`define PAEM_CFG_XOVER_EXT       0
`define PAEM_MCS_SLEEP_EN        13
`define PAEM_MCS_ENERGY          1
`define PAEM_MCS_SPARE           0
`define PAEM_OPM_MODE_HI         7
`define PAEM_OPM_MODE_LO         5
`define PAEM_OPM_ADDR_HI         4
`define PAEM_OPM_ADDR_LO         0

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PAEM_RST_MODE            3'h7
`define PAEM_RST_ADDR            5'h01
`define PAEM_RST_ENERGY          1'b1
`define PAEM_RST_TX_IVAL         2'h0
`define PAEM_RST_RX_IVAL         2'h0

// ---------------------------------------------------------------
// frame fields of the serial management interface
// ---------------------------------------------------------------
`define PAEM_PREAMBLE_BITS       6'h20
`define PAEM_OP_READ             2'h2
`define PAEM_OP_WRITE            2'h1

// ---------------------------------------------------------------
// mode codes
// ---------------------------------------------------------------
`define PAEM_MODE_10_HD          3'h0
`define PAEM_MODE_10_FD          3'h1
`define PAEM_MODE_100_HD         3'h2
`define PAEM_MODE_100_FD         3'h3
`define PAEM_MODE_AN_100_HD      3'h4
`define PAEM_MODE_REPEATER       3'h5
`define PAEM_MODE_ALL_CAPABLE    3'h7
`define PAEM_ADV_100_HD          4'h4
`define PAEM_ADV_ALL             4'hF

// ---------------------------------------------------------------
// timing: figures in ms, clock period in ns, derived cycles per ms
// ---------------------------------------------------------------
`define PAEM_CLK_PERIOD_NS       20
`define PAEM_MS_CYCLES           (1000000 / `PAEM_CLK_PERIOD_NS)
`define PAEM_TX_IVAL_0_MS        10'd1000
`define PAEM_TX_IVAL_1_MS        10'd768
`define PAEM_TX_IVAL_2_MS        10'd512
`define PAEM_TX_IVAL_3_MS        10'd256
`define PAEM_RX_IVAL_0_MS        10'd64
`define PAEM_RX_IVAL_1_MS        10'd256
`define PAEM_RX_IVAL_2_MS        10'd512
`define PAEM_RX_IVAL_3_MS        10'd1000
`define PAEM_ENERGY_TIMEOUT_MS   9'd256
`define PAEM_XOVER_EXT_MS        11'd1984

`endif

// ==== src/paem_phy_regs.v ====
// auto-negotiation expansion, energy-detect sleep and operating-mode registers
`timescale 1ns/1ps
`include "paem_regs.vh"

module paem_phy_regs #(
	parameter MS_CYCLES = `PAEM_MS_CYCLES
) (
	input  wire        CLK_SYS_I,
	input  wire        RST_I,
	input  wire        SOFT_RST_I,
	input  wire        MDC_I,
	input  wire        MDIO_I,
	output reg         MDIO_O,
	output reg         MDIO_OE_O,
	input  wire        PD_FAULT_I,
	input  wire        PAGE_RX_I,
	input  wire        LP_NP_ABLE_I,
	input  wire        LP_AN_ABLE_I,
	input  wire        ENERGY_DET_I,
	input  wire        NLP_RX_I,
	input  wire        MDIX_EN_I,
	output reg         NLP_TX_O,
	output reg         WAKE_O,
	output reg         SLEEP_O,
	output reg  [10:0] XOVER_EXT_MS_O,
	output reg         AN_EN_O,
	output reg         SPEED_100_O,
	output reg         FULL_DUPLEX_O,
	output reg         REPEATER_O,
	output reg         CRS_ON_TX_O,
	output reg  [3:0]  ADV_ABILITY_O,
	output reg  [2:0]  MODE_O,
	output reg  [4:0]  PHY_ADDR_O
);

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	localparam [3:0]  S_PRE  = 4'h1;              // hunting preamble
	localparam [3:0]  S_HDR  = 4'h2;              // start, opcode, addresses
	localparam [3:0]  S_TA   = 4'h4;              // turnaround
	localparam [3:0]  S_DATA = 4'h8;              // sixteen data bits
	localparam [15:0] MS_LAST = MS_CYCLES[15:0] - 16'h0001; // last cycle of a ms

	reg  [2:0]  mdc_s;                            // pin synchroniser
	reg  [2:0]  mdio_s;                           // pin synchroniser
	reg         mdc_f;                            // filtered clock level
	reg         mdio_f;                           // filtered data level
	reg  [3:0]  state;                            // frame state
	reg  [5:0]  pre_cnt;                          // consecutive ones
	reg  [3:0]  bit_cnt;                          // bit within field
	reg  [11:0] hdr;                              // header shift
	reg         is_rd;                            // frame is a read
	reg  [4:0]  reg_idx;                          // addressed register
	reg  [15:0] rd_sh;                            // read shift
	reg  [15:0] wr_sh;                            // write shift
	reg         wr_stb;                           // write commit pulse
	reg  [15:0] wr_data;                          // word to commit
	reg  [15:0] rd_word;                          // read mux
	reg         pd_fault;                         // latched fault
	reg         page_rx;                          // latched page
	reg         tx_nlp_en;                        // transmit pulse enable
	reg  [1:0]  tx_ival;                          // transmit interval code
	reg         rx_single;                        // single pulse wake
	reg  [1:0]  rx_ival;                          // receive window code
	reg         xover_ext;                        // crossover extension
	reg         sleep_en;                         // sleep enable
	reg         spare_bit;                        // writable spare bit
	reg         energy;                           // line energy present
	reg  [2:0]  mode;                             // operating mode
	reg  [4:0]  addr;                             // management address
	reg  [15:0] ms_cnt;                           // ms divider
	reg         ms_tick;                          // one pulse per ms
	reg  [8:0]  en_cnt;                           // ms without energy
	reg  [9:0]  tx_cnt;                           // ms since last pulse
	reg  [9:0]  rx_gap;                           // ms since first pulse
	reg         rx_seen;                          // first pulse held
	reg  [9:0]  tx_lim;                           // transmit interval ms
	reg  [9:0]  rx_lim;                           // receive window ms

	wire mdc_n   = (mdc_s[1] == mdc_s[2]) ? mdc_s[2] : mdc_f;
	wire mdio_n  = (mdio_s[1] == mdio_s[2]) ? mdio_s[2] : mdio_f;
	wire rise    = mdc_n & ~mdc_f;                // accepted clock rise
	wire [12:0] hfull  = {hdr, mdio_n};           // complete header
	wire hdr_end = rise & state[1] & (bit_cnt == 4'hC);
	wire hit     = hfull[12] & (hfull[9:5] == addr);
	wire rd_go   = hdr_end & hit & (hfull[11:10] == `PAEM_OP_READ);
	wire wr_go   = hdr_end & hit & (hfull[11:10] == `PAEM_OP_WRITE);
	wire rd_clr  = rd_go & (hfull[4:0] == `PAEM_IDX_AUTONEG_EXPANSION_STATUS);
	wire sleep   = sleep_en & ~energy;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	// three stages; a level counts once stages two and three agree
	always @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			mdc_s  <= 3'h0;
			mdio_s <= 3'h7;
			mdc_f  <= 1'b0;
			mdio_f <= 1'b1;
		end else begin
			mdc_s  <= {mdc_s[1:0], MDC_I};
			mdio_s <= {mdio_s[1:0], MDIO_I};
			mdc_f  <= mdc_n;
			mdio_f <= mdio_n;
		end
	end

	// ---------------------------------------------------------------
	// read mux
	// ---------------------------------------------------------------
	always @* begin
		rd_word = 16'h0000;
		case (hfull[4:0])
			`PAEM_IDX_AUTONEG_EXPANSION_STATUS: begin
				rd_word[`PAEM_EXP_PD_FAULT]   = pd_fault;
				rd_word[`PAEM_EXP_LP_NP_ABLE] = LP_NP_ABLE_I;
				rd_word[`PAEM_EXP_NP_ABLE]    = 1'b0;
				rd_word[`PAEM_EXP_PAGE_RX]    = page_rx;
				rd_word[`PAEM_EXP_LP_AN_ABLE] = LP_AN_ABLE_I;
			end
			`PAEM_IDX_SLEEP_XOVER_CFG: begin
				rd_word[15:10] = {tx_nlp_en, tx_ival, rx_single, rx_ival};
				rd_word[`PAEM_CFG_XOVER_EXT] = xover_ext;
			end
			`PAEM_IDX_ENERGY_MODE: begin
				rd_word[`PAEM_MCS_SLEEP_EN] = sleep_en;
				rd_word[`PAEM_MCS_ENERGY]   = energy;
				rd_word[`PAEM_MCS_SPARE]    = spare_bit;
			end
			`PAEM_IDX_OPMODE_ADDR: begin
				rd_word[7:0] = {mode, addr};
			end
			default: begin
				rd_word = 16'h0000;                // unmapped reads zero
			end
		endcase
	end

	// ---------------------------------------------------------------
	// management frame engine
	// ---------------------------------------------------------------
	// outputs change just after an accepted clock rise
	always @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			state     <= S_PRE;
			pre_cnt   <= 6'h00;
			bit_cnt   <= 4'h0;
			hdr       <= 12'h000;
			is_rd     <= 1'b0;
			reg_idx   <= 5'h00;
			rd_sh     <= 16'h0000;
			wr_sh     <= 16'h0000;
			wr_stb    <= 1'b0;
			wr_data   <= 16'h0000;
			MDIO_O    <= 1'b0;
			MDIO_OE_O <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			if (rise) begin
				case (state)
					S_PRE: begin
						// count ones, a zero after 32 starts a frame
						if (mdio_n) begin
							if (pre_cnt != `PAEM_PREAMBLE_BITS) begin
								pre_cnt <= pre_cnt + 6'h01;
							end
						end else if (pre_cnt == `PAEM_PREAMBLE_BITS) begin
							state   <= S_HDR;
							bit_cnt <= 4'h0;
							pre_cnt <= 6'h00;
						end else begin
							pre_cnt <= 6'h00;
						end
					end
					S_HDR: begin
						hdr     <= hfull[11:0];
						bit_cnt <= bit_cnt + 4'h1;
						if (hdr_end) begin
							bit_cnt <= 4'h0;
							reg_idx <= hfull[4:0];
							is_rd   <= rd_go;
							rd_sh   <= rd_word;
							if (rd_go | wr_go) begin
								state <= S_TA;
							end else begin
								state <= S_PRE;
							end
						end
					end
					S_TA: begin
						bit_cnt <= 4'h0;
						if (bit_cnt == 4'h0) begin
							bit_cnt <= 4'h1;
							if (is_rd) begin
								MDIO_O    <= 1'b0;     // second turnaround bit
								MDIO_OE_O <= 1'b1;
							end
						end else begin
							state <= S_DATA;
							if (is_rd) begin
								MDIO_O <= rd_sh[15];
								rd_sh  <= {rd_sh[14:0], 1'b0};
							end
						end
					end
					S_DATA: begin
						bit_cnt <= bit_cnt + 4'h1;
						if (is_rd) begin
							MDIO_O <= rd_sh[15];
							rd_sh  <= {rd_sh[14:0], 1'b0};
						end else begin
							wr_sh <= {wr_sh[14:0], mdio_n};
						end
						if (bit_cnt == 4'hF) begin
							state     <= S_PRE;
							MDIO_OE_O <= 1'b0;        // release the line
							MDIO_O    <= 1'b0;
							wr_stb    <= ~is_rd;
							wr_data   <= {wr_sh[14:0], mdio_n};
						end
					end
					default: begin
						state     <= S_PRE;
						MDIO_OE_O <= 1'b0;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// registers cleared by soft reset
	// ---------------------------------------------------------------
	always @(posedge CLK_SYS_I) begin
		if (RST_I | SOFT_RST_I) begin
			pd_fault  <= 1'b0;
			page_rx   <= 1'b0;
			tx_nlp_en <= 1'b0;
			tx_ival   <= `PAEM_RST_TX_IVAL;
			rx_single <= 1'b0;
			rx_ival   <= `PAEM_RST_RX_IVAL;
			xover_ext <= 1'b0;
			sleep_en  <= 1'b0;
			spare_bit <= 1'b0;
		end else begin
			// read clears, a new event wins
			pd_fault <= PD_FAULT_I | (pd_fault & ~rd_clr);
			page_rx  <= PAGE_RX_I | (page_rx & ~rd_clr);
			if (wr_stb && reg_idx == `PAEM_IDX_SLEEP_XOVER_CFG) begin
				tx_nlp_en <= wr_data[`PAEM_CFG_TX_NLP_EN];
				tx_ival   <= wr_data[`PAEM_CFG_TX_IVAL_HI:`PAEM_CFG_TX_IVAL_LO];
				rx_single <= wr_data[`PAEM_CFG_RX_SINGLE_WAKE];
				rx_ival   <= wr_data[`PAEM_CFG_RX_IVAL_HI:`PAEM_CFG_RX_IVAL_LO];
				xover_ext <= wr_data[`PAEM_CFG_XOVER_EXT];
			end
			if (wr_stb && reg_idx == `PAEM_IDX_ENERGY_MODE) begin
				sleep_en  <= wr_data[`PAEM_MCS_SLEEP_EN];
				spare_bit <= wr_data[`PAEM_MCS_SPARE];
			end
		end
	end

	// ---------------------------------------------------------------
	// fields kept over soft reset
	// ---------------------------------------------------------------
	// hard reset only
	always @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			mode <= `PAEM_RST_MODE;
			addr <= `PAEM_RST_ADDR;
		end else if (wr_stb && reg_idx == `PAEM_IDX_OPMODE_ADDR) begin
			mode <= wr_data[`PAEM_OPM_MODE_HI:`PAEM_OPM_MODE_LO];
			addr <= wr_data[`PAEM_OPM_ADDR_HI:`PAEM_OPM_ADDR_LO];
		end
	end

	// ---------------------------------------------------------------
	// millisecond divider and energy timeout
	// ---------------------------------------------------------------
	always @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			ms_cnt  <= 16'h0000;
			ms_tick <= 1'b0;
			energy  <= `PAEM_RST_ENERGY;
			en_cnt  <= 9'h000;
		end else begin
			ms_tick <= (ms_cnt == MS_LAST);
			ms_cnt  <= (ms_cnt == MS_LAST) ? 16'h0000 : ms_cnt + 16'h0001;
			if (ENERGY_DET_I) begin
				energy <= 1'b1;
				en_cnt <= 9'h000;
			end else if (ms_tick && energy) begin
				if (en_cnt == `PAEM_ENERGY_TIMEOUT_MS - 9'd1) begin
					energy <= 1'b0;
					en_cnt <= 9'h000;
				end else begin
					en_cnt <= en_cnt + 9'h001;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// interval decode
	// ---------------------------------------------------------------
	always @* begin
		case (tx_ival)
			2'h0:    tx_lim = `PAEM_TX_IVAL_0_MS;
			2'h1:    tx_lim = `PAEM_TX_IVAL_1_MS;
			2'h2:    tx_lim = `PAEM_TX_IVAL_2_MS;
			default: tx_lim = `PAEM_TX_IVAL_3_MS;
		endcase
		case (rx_ival)
			2'h0:    rx_lim = `PAEM_RX_IVAL_0_MS;
			2'h1:    rx_lim = `PAEM_RX_IVAL_1_MS;
			2'h2:    rx_lim = `PAEM_RX_IVAL_2_MS;
			default: rx_lim = `PAEM_RX_IVAL_3_MS;
		endcase
	end

	// ---------------------------------------------------------------
	// sleep pulses and wake detection
	// ---------------------------------------------------------------
	always @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			tx_cnt   <= 10'h000;
			rx_gap   <= 10'h000;
			rx_seen  <= 1'b0;
			NLP_TX_O <= 1'b0;
			WAKE_O   <= 1'b0;
			SLEEP_O  <= 1'b0;
		end else begin
			NLP_TX_O <= 1'b0;
			WAKE_O   <= 1'b0;
			SLEEP_O  <= sleep;
			// single pulses while sleeping and enabled
			if (sleep && tx_nlp_en) begin
				if (ms_tick) begin
					if (tx_cnt == tx_lim - 10'd1) begin
						tx_cnt   <= 10'h000;
						NLP_TX_O <= 1'b1;
					end else begin
						tx_cnt <= tx_cnt + 10'h001;
					end
				end
			end else begin
				tx_cnt <= 10'h000;
			end
			if (!sleep) begin
				rx_seen <= 1'b0;
				rx_gap  <= 10'h000;
			end else if (NLP_RX_I) begin
				if (rx_single) begin
					WAKE_O <= 1'b1;
				end else if (rx_seen && rx_gap <= rx_lim) begin
					WAKE_O  <= 1'b1;
					rx_seen <= 1'b0;
				end else begin
					rx_seen <= 1'b1;
					rx_gap  <= 10'h000;
				end
			end else if (ms_tick && rx_seen) begin
				if (rx_gap >= rx_lim) begin
					rx_seen <= 1'b0;                  // window expired
				end else begin
					rx_gap <= rx_gap + 10'h001;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// mode decode and crossover extension
	// ---------------------------------------------------------------
	always @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			AN_EN_O        <= 1'b1;
			SPEED_100_O    <= 1'b1;
			FULL_DUPLEX_O  <= 1'b1;
			REPEATER_O     <= 1'b0;
			CRS_ON_TX_O    <= 1'b0;
			ADV_ABILITY_O  <= `PAEM_ADV_ALL;
			MODE_O         <= `PAEM_RST_MODE;
			PHY_ADDR_O     <= `PAEM_RST_ADDR;
			XOVER_EXT_MS_O <= 11'h000;
		end else begin
			MODE_O     <= mode;
			PHY_ADDR_O <= addr;
			REPEATER_O <= 1'b0;
			case (mode)
				`PAEM_MODE_10_HD, `PAEM_MODE_10_FD: begin
					AN_EN_O       <= 1'b0;
					SPEED_100_O   <= 1'b0;
					FULL_DUPLEX_O <= mode[0];
					CRS_ON_TX_O   <= ~mode[0];
					ADV_ABILITY_O <= 4'h0;
				end
				`PAEM_MODE_100_HD, `PAEM_MODE_100_FD: begin
					AN_EN_O       <= 1'b0;
					SPEED_100_O   <= 1'b1;
					FULL_DUPLEX_O <= mode[0];
					CRS_ON_TX_O   <= ~mode[0];
					ADV_ABILITY_O <= 4'h0;
				end
				`PAEM_MODE_AN_100_HD: begin
					AN_EN_O       <= 1'b1;
					SPEED_100_O   <= 1'b1;
					FULL_DUPLEX_O <= 1'b0;
					CRS_ON_TX_O   <= 1'b1;
					ADV_ABILITY_O <= `PAEM_ADV_100_HD;
				end
				`PAEM_MODE_REPEATER: begin
					AN_EN_O       <= 1'b1;
					SPEED_100_O   <= 1'b1;
					FULL_DUPLEX_O <= 1'b0;
					CRS_ON_TX_O   <= 1'b0;
					REPEATER_O    <= 1'b1;
					ADV_ABILITY_O <= `PAEM_ADV_100_HD;
				end
				// all capable; reserved code acts alike
				default: begin
					AN_EN_O       <= 1'b1;
					SPEED_100_O   <= 1'b1;
					FULL_DUPLEX_O <= 1'b1;
					CRS_ON_TX_O   <= 1'b0;
					ADV_ABILITY_O <= `PAEM_ADV_ALL;
				end
			endcase
			if (MDIX_EN_I && xover_ext && !mode[2]) begin
				XOVER_EXT_MS_O <= `PAEM_XOVER_EXT_MS;
			end else begin
				XOVER_EXT_MS_O <= 11'h000;
			end
		end
	end

endmodule

// ==== verification/paem_checker.sv ====
// checker of mode decode, pulses and management drive at the block ports
`timescale 1ns/1ps
module paem_checker (
	input wire        CLK_SYS_I,
	input wire        RST_I,
	input wire        MDIO_O,
	input wire        MDIO_OE_O,
	input wire        MDIX_EN_I,
	input wire        NLP_RX_I,
	input wire        NLP_TX_O,
	input wire        WAKE_O,
	input wire [10:0] XOVER_EXT_MS_O,
	input wire        AN_EN_O,
	input wire        SPEED_100_O,
	input wire        FULL_DUPLEX_O,
	input wire        REPEATER_O,
	input wire        CRS_ON_TX_O,
	input wire [3:0]  ADV_ABILITY_O,
	input wire [2:0]  MODE_O,
	input wire [4:0]  PHY_ADDR_O
);
	// ------------------------------------------
	// one clock domain, hard reset disables
	// ------------------------------------------
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (RST_I);
	property p_rst;
		$past(RST_I) |-> MODE_O == 3'h7 && PHY_ADDR_O == 5'h01 && !MDIO_OE_O;
	endproperty
	a_rst: assert property (p_rst) else $error("bad state after reset");
	property p_manual;
		MODE_O < 3'h4 |-> !AN_EN_O && ADV_ABILITY_O == 4'h0 && SPEED_100_O == MODE_O[1]
			&& FULL_DUPLEX_O == MODE_O[0];
	endproperty
	a_manual: assert property (p_manual) else $error("manual mode decode");
	property p_crs;
		MODE_O inside {3'h2, 3'h3} |-> CRS_ON_TX_O != MODE_O[0];
	endproperty
	a_crs: assert property (p_crs) else $error("carrier sense decode");
	property p_adv100;
		MODE_O inside {3'h4, 3'h5} |-> AN_EN_O && ADV_ABILITY_O == 4'h4
			&& REPEATER_O == MODE_O[0] && CRS_ON_TX_O != MODE_O[0];
	endproperty
	a_adv100: assert property (p_adv100) else $error("half duplex advert");
	property p_all;
		MODE_O == 3'h7 |-> AN_EN_O && ADV_ABILITY_O == 4'hF;
	endproperty
	a_all: assert property (p_all) else $error("all capable advert");
	property p_xover;
		XOVER_EXT_MS_O != 11'd0 |-> XOVER_EXT_MS_O == 11'd1984 && !MODE_O[2] && $past(MDIX_EN_I);
	endproperty
	a_xover: assert property (p_xover) else $error("crossover extension");
	property p_wake;
		WAKE_O |-> $past(NLP_RX_I) ##1 !WAKE_O;
	endproperty
	a_wake: assert property (p_wake) else $error("wake without pulse");
	property p_tx;
		NLP_TX_O |=> !NLP_TX_O [*8];
	endproperty
	a_tx: assert property (p_tx) else $error("link pulses too close");
	property p_ta;
		$rose(MDIO_OE_O) |-> !MDIO_O ##1 MDIO_OE_O [*8];
	endproperty
	a_ta: assert property (p_ta) else $error("turnaround drive");
endmodule
bind paem_phy_regs paem_checker u_paem_checker (
	.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .MDIO_O(MDIO_O), .MDIO_OE_O(MDIO_OE_O),
	.MDIX_EN_I(MDIX_EN_I), .NLP_RX_I(NLP_RX_I), .NLP_TX_O(NLP_TX_O), .WAKE_O(WAKE_O),
	.XOVER_EXT_MS_O(XOVER_EXT_MS_O), .AN_EN_O(AN_EN_O), .SPEED_100_O(SPEED_100_O),
	.FULL_DUPLEX_O(FULL_DUPLEX_O), .REPEATER_O(REPEATER_O), .CRS_ON_TX_O(CRS_ON_TX_O),
	.ADV_ABILITY_O(ADV_ABILITY_O), .MODE_O(MODE_O), .PHY_ADDR_O(PHY_ADDR_O));

// ==== verification/paem_mgmt_host.sv ====
// station management host driving frames on the management pins
`timescale 1ns/1ps
module paem_mgmt_host (
	input  wire clk_i,
	input  wire mdio_i,
	output reg  mdc_o,
	output reg  mdio_o,
	output reg  mdio_oe_o
);
	// idle: clock still low, line released
	initial begin
		mdc_o = 1'b0;
		mdio_o = 1'b1;
		mdio_oe_o = 1'b0;
	end
	// one whole frame, 12 system clocks per management clock
	task automatic frame(input [1:0] op, input [4:0] pa, input [4:0] ra,
		input [15:0] wd, output [15:0] rd);
		reg [63:0] f;
		integer i;
		begin
			f = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
			rd = 16'h0000;
			for (i = 0; i < 64; i = i + 1) begin
				@(negedge clk_i);
				mdc_o = 1'b0;
				// read frames release the line after the register bits
				mdio_oe_o = (op == 2'h1) || (i < 46);
				mdio_o = f[63 - i];
				repeat (6) @(negedge clk_i);
				if (i >= 48) rd = {rd[14:0], mdio_i};
				mdc_o = 1'b1;
				repeat (5) @(negedge clk_i);
			end
			@(negedge clk_i);
			mdc_o = 1'b0;
			mdio_oe_o = 1'b0;
		end
	endtask
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench of the mode register bank
`timescale 1ns/1ps
module tb_top;
	localparam MS = 5;
	reg clk, rst, srst, pdf, pgr, lpnp, lpan, edet, nrx, mdix;
	wire mdc, hd, hoe, mo, moe, ntx, wake, slp, an, s100, fd, rep, crs;
	wire [10:0] xo;
	wire [3:0]  adv;
	wire [2:0]  mode;
	wire [4:0]  pa;
	// pull-up on the shared data line
	wire        mdio = moe ? mo : (hoe ? hd : 1'b1);
	integer     fails, check_count, cyc;
	reg  [4:0]  adr;
	reg  [15:0] rd;
	paem_phy_regs #(.MS_CYCLES(MS)) u_paem_phy_regs (.CLK_SYS_I(clk), .RST_I(rst),
		.SOFT_RST_I(srst), .MDC_I(mdc), .MDIO_I(mdio), .MDIO_O(mo), .MDIO_OE_O(moe),
		.PD_FAULT_I(pdf), .PAGE_RX_I(pgr), .LP_NP_ABLE_I(lpnp), .LP_AN_ABLE_I(lpan),
		.ENERGY_DET_I(edet), .NLP_RX_I(nrx), .MDIX_EN_I(mdix), .NLP_TX_O(ntx),
		.WAKE_O(wake), .SLEEP_O(slp), .XOVER_EXT_MS_O(xo), .AN_EN_O(an),
		.SPEED_100_O(s100), .FULL_DUPLEX_O(fd), .REPEATER_O(rep), .CRS_ON_TX_O(crs),
		.ADV_ABILITY_O(adv), .MODE_O(mode), .PHY_ADDR_O(pa));
	paem_mgmt_host u_paem_mgmt_host (.clk_i(clk), .mdio_i(mdio), .mdc_o(mdc),
		.mdio_o(hd), .mdio_oe_o(hoe));
	always #10 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	task check(input [63:0] seen, input [63:0] exp, input [8*8:1] nm);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("unexpected %0s expected %0h seen %0h", nm, exp, seen);
			end
		end
	endtask
	task rr(input [4:0] ra, input [15:0] exp);
		begin
			u_paem_mgmt_host.frame(2'h2, adr, ra, 16'h0000, rd);
			check(rd, exp, "read");
		end
	endtask
	task ww(input [4:0] ra, input [15:0] wd);
		begin
			u_paem_mgmt_host.frame(2'h1, adr, ra, wd, rd);
			repeat (3) @(negedge clk);
		end
	endtask
	// bounded wait for the next transmitted pulse, returns its cycle
	task wt(output integer t);
		integer n;
		begin
			n = 0;
			while (ntx !== 1'b1 && n < 6000) begin
				@(negedge clk);
				n = n + 1;
			end
			check(n < 6000, 1, "pulse");
			t = cyc;
			@(negedge clk);
		end
	endtask
	// received pulse, reports any wake in the next two cycles
	task rx(output reg w);
		begin
			nrx = 1'b1;
			@(negedge clk);
			nrx = 1'b0;
			w = wake;
			@(negedge clk);
			w = w | wake;
		end
	endtask
	task t_reset;
		begin
			rr(5'h12, 16'h00E1);
			rr(5'h11, 16'h0002);
			rr(5'h10, 16'h0000);
			rr(5'h06, 16'h0000);
			rr(5'h05, 16'h0000);
		end
	endtask
	task t_latch;
		begin
			lpnp = 1'b1;
			lpan = 1'b1;
			pdf = 1'b1;
			pgr = 1'b1;
			@(negedge clk);
			pdf = 1'b0;
			pgr = 1'b0;
			rr(5'h06, 16'h001B);
			rr(5'h06, 16'h0009);
			// fault held across a clearing read keeps the bit set
			pdf = 1'b1;
			rr(5'h06, 16'h0019);
			pdf = 1'b0;
			rr(5'h06, 16'h0019);
			rr(5'h06, 16'h0009);
			lpnp = 1'b0;
			lpan = 1'b0;
		end
	endtask
	task t_modes;
		integer m;
		reg [2:0] c;
		begin
			ww(5'h10, 16'h0001);
			for (m = 0; m < 8; m = m + 1) begin
				c = m[2:0];
				// reserved code is skipped by the test loop
				if (c != 3'h6) begin
					ww(5'h12, {8'h00, c, 5'h01});
					check({an, s100, fd, rep, adv}, {c[2], c > 3'h1, c == 3'h1 || c == 3'h3 ||
						c == 3'h7, c == 3'h5, c == 3'h7 ? 4'hF : (c[2] ? 4'h4 : 4'h0)}, "mode");
					if (c > 3'h1 && c < 3'h6) check(crs, c == 3'h2 || c == 3'h4, "crs");
					check(xo, c[2] ? 11'd0 : 11'd1984, "xover");
					check(mode, c, "mode_o");
				end
			end
			// crossover off: no extension even in a manual mode
			mdix = 1'b0;
			ww(5'h12, 16'h0001);
			check(xo, 11'd0, "xover");
			mdix = 1'b1;
		end
	endtask
	task t_keep;
		begin
			ww(5'h12, 16'h0045);
			adr = 5'h05;
			check(pa, 5'h05, "addr");
			srst = 1'b1;
			@(negedge clk);
			srst = 1'b0;
			rr(5'h12, 16'h0045);
			rr(5'h10, 16'h0000);
			adr = 5'h01;
			ww(5'h10, 16'h0001);
			// old address gets no answer, line stays at the pull-up
			rr(5'h12, 16'hFFFF);
			adr = 5'h05;
			rr(5'h10, 16'h0000);
			rst = 1'b1;
			repeat (2) @(negedge clk);
			rst = 1'b0;
			repeat (4) @(negedge clk);
			adr = 5'h01;
			rr(5'h12, 16'h00E1);
		end
	endtask
	task t_sleep;
		integer c, a, b, n;
		reg [15:0] iv [0:3];
		begin
			iv[0] = 1000; iv[1] = 768; iv[2] = 512; iv[3] = 256;
			edet = 1'b0;
			ww(5'h11, 16'h2000);
			n = 0;
			while (slp !== 1'b1 && n < 3000) begin
				@(negedge clk);
				n = n + 1;
			end
			check(slp, 1, "sleep");
			rr(5'h11, 16'h2000);
			for (c = 3; c >= 0; c = c - 1) begin
				ww(5'h10, 16'h8000 | (c << 13));
				wt(a);
				wt(b);
				check(b - a >= iv[c] * MS - MS - 2 && b - a <= iv[c] * MS + MS + 2, 1, "gap");
			end
			ww(5'h10, 16'h6000);
			n = 0;
			repeat (3000) begin
				@(negedge clk);
				n = n + ntx;
			end
			check(n, 0, "no_pulse");
		end
	endtask
	task t_wake;
		reg w;
		begin
			ww(5'h10, 16'h1000);
			rx(w);
			check(w, 1, "wake1");
			ww(5'h10, 16'h0000);
			rx(w);
			repeat (100) @(negedge clk);
			rx(w);
			check(w, 1, "wake2");
			repeat (400) @(negedge clk);
			rx(w);
			repeat (400) @(negedge clk);
			rx(w);
			check(w, 0, "late");
			srst = 1'b1;
			@(negedge clk);
			srst = 1'b0;
			rr(5'h11, 16'h0000);
			edet = 1'b1;
			rr(5'h11, 16'h0002);
		end
	endtask
	task results;
		begin
			$display("checks %0d fails %0d", check_count, fails);
			if (fails == 0 && check_count > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	initial begin
		// tests need about 60000 cycles
		repeat (90000) @(posedge clk);
		fails = fails + 1;
		results;
	end
	initial begin
		clk = 0; rst = 1; srst = 0; pdf = 0; pgr = 0; lpnp = 0; lpan = 0;
		edet = 1; nrx = 0; mdix = 1; fails = 0; check_count = 0; cyc = 0; adr = 5'h01;
		repeat (2) @(negedge clk);
		rst = 0;
		repeat (4) @(negedge clk);
		t_reset;
		t_latch;
		t_modes;
		t_keep;
		t_sleep;
		t_wake;
		results;
	end
endmodule
